// ==== hw/ppt_regs.vh ====
/*
  Register offsets, reset values and mode codes of the three parallel ports.
  Assumes it is included by bare name by every design file that needs it.
*/
`ifndef PPT_REGS_VH
`define PPT_REGS_VH

// ==========================================================================
// Register offsets
`define PPT_OFS_A_DATA 8'h00
`define PPT_OFS_A_DIR 8'h01
`define PPT_OFS_B_DIR 8'h02
`define PPT_OFS_B_DATA 8'h04
`define PPT_OFS_C_DATA 8'h06
`define PPT_OFS_C_DIR 8'h07

// ==========================================================================
// Reset values and constants
`define PPT_DIR_RESET 8'h00
`define PPT_ZERO8 8'h00
`define PPT_ONES8 8'hff

// ==========================================================================
// Operating mode codes
`define PPT_MODE_SINGLE 2'h0
`define PPT_MODE_EXPANDED 2'h1
`define PPT_MODE_BOOT 2'h2
`define PPT_MODE_TEST 2'h3

// ==========================================================================
// Input synchroniser depth
`define PPT_SYNC_STAGES 3

`endif

// ==== hw/ppt_sync.v ====
/*
  Three-flop synchroniser with agreement filter for a bundle of pin inputs.
  Assumes pins are asynchronous to core_clk; output follows a change once
  the second and third stages agree.
*/
`include "ppt_regs.vh"

module ppt_sync #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  // Pins in, filtered level out
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] level
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;

  // ==========================================================================
  // Sync chain; stage1 feeds only stage2
  always @(posedge core_clk) begin
    if (sys_rst) begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
      stage3 <= {WIDTH{1'b0}};
      level <= {WIDTH{1'b0}};
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      // Take bits where stages two and three agree
      level <= (stage2 & stage3) | (level & (stage2 | stage3));
    end
  end

endmodule

// ==== hw/ppt_ports.v ====
/*
  Parallel ports A, B and C: data latches, direction registers, timer
  alternate functions on port A, and address/data bus takeover of ports
  B and C in expanded and test modes.
  Assumes the mode comes from the mode-select logic and the timer enables and
  values come from the timer block; all on core_clk. Pin wires are resolved
  outside from the output enables.
*/
// The plain strobed port was decided locally.
//
// Contract
// RL1: Port A has eight two-way lines, each steered by one latch bit and one direction bit.
// RL2: After reset every port A line is an input with its driver off.
// RL3: Port A latch is always readable and writable, untouched by reset, and ignored by pins in alternate use.
// RL4: A direction bit of one makes the pin an output, zero an input, and direction resets to zero.
// RL5: Port A bits carry captures 3,2,1, then compare 5/1 or capture 4, compares 4..2 with 1, and pulse input with 1.
// RL6: In expanded or test mode port B drives address bits 8 to 15 and its registers leave the map.
// RL7: In single chip or bootstrap mode port B comes out of reset as high-impedance inputs.
// RL8: In expanded or test mode port C is the two-way data bus and its registers leave the map.
// RL9: In single chip or bootstrap mode port C comes out of reset as high-impedance inputs.
// RL10: Port B and C latches are readable and writable while mapped and untouched by reset.
// RL11: Latch contents are undefined after reset and pin state at reset depends only on mode.
// RL12: Address and data use separate pin groups so both work at once in expanded mode.
// RL13: A data read returns the pin level for input bits and the latch for output bits.
`include "ppt_regs.vh"

module ppt_ports #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Operating mode
  input wire [1:0] op_mode,
  // Timer alternate functions on port A
  input wire [7:0] timer_out_en,
  input wire [7:0] timer_out_val,
  output reg [7:0] timer_in,
  // External bus in expanded mode
  input wire [7:0] bus_addr_high,
  input wire [7:0] bus_wdata,
  input wire bus_drive,
  output reg [7:0] bus_rdata,
  // Port A pins
  input wire [WIDTH-1:0] first_pin_in,
  output reg [WIDTH-1:0] first_pin_out,
  output reg [WIDTH-1:0] first_pin_oe,
  // Port B pins
  input wire [WIDTH-1:0] second_pin_in,
  output reg [WIDTH-1:0] second_pin_out,
  output reg [WIDTH-1:0] second_pin_oe,
  // Port C pins
  input wire [WIDTH-1:0] third_pin_in,
  output reg [WIDTH-1:0] third_pin_out,
  output reg [WIDTH-1:0] third_pin_oe
);

  // Latches have no reset; direction registers do
  reg [WIDTH-1:0] first_port_latch;
  reg [WIDTH-1:0] first_port_direction;
  reg [WIDTH-1:0] second_port_latch;
  reg [WIDTH-1:0] second_port_direction;
  reg [WIDTH-1:0] third_port_latch;
  reg [WIDTH-1:0] third_port_direction;
  wire [WIDTH-1:0] first_level;
  wire [WIDTH-1:0] second_level;
  wire [WIDTH-1:0] third_level;
  reg bus_mode;
  reg [7:0] next_rdata;
  reg [WIDTH-1:0] next_first_out;
  reg [WIDTH-1:0] next_first_oe;

  // Pin level for inputs, latch for outputs
  function [WIDTH-1:0] ppt_read_mix;
    input [WIDTH-1:0] dir;
    input [WIDTH-1:0] latch;
    input [WIDTH-1:0] level;
    begin
      ppt_read_mix = (dir & latch) | (~dir & level);
    end
  endfunction

  // Expanded or test mode takes over ports B and C
  function ppt_is_bus;
    input [1:0] mode;
    begin
      ppt_is_bus = (mode == `PPT_MODE_EXPANDED) || (mode == `PPT_MODE_TEST);
    end
  endfunction

  // ==========================================================================
  // Input synchronisers
  ppt_sync #(.WIDTH(WIDTH)) u_sync_a (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin_in(first_pin_in),
    .level(first_level)
  );

  ppt_sync #(.WIDTH(WIDTH)) u_sync_b (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin_in(second_pin_in),
    .level(second_level)
  );

  ppt_sync #(.WIDTH(WIDTH)) u_sync_c (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin_in(third_pin_in),
    .level(third_level)
  );

  // ==========================================================================
  // Mode decode, registered
  always @(posedge core_clk) begin
    if (sys_rst) begin
      bus_mode <= 1'b0;
    end else begin
      bus_mode <= ppt_is_bus(op_mode);
    end
  end

  // ==========================================================================
  // Data latches: A written any time, B and C only outside bus mode; never reset
  always @(posedge core_clk) begin
    if (reg_wr && reg_addr == `PPT_OFS_A_DATA) begin
      first_port_latch <= reg_wdata[WIDTH-1:0]; // [RL3] [RL11]
    end
    if (reg_wr && !ppt_is_bus(op_mode) && reg_addr == `PPT_OFS_B_DATA) begin
      second_port_latch <= reg_wdata[WIDTH-1:0]; // [RL10] [RL6]
    end
    if (reg_wr && !ppt_is_bus(op_mode) && reg_addr == `PPT_OFS_C_DATA) begin
      third_port_latch <= reg_wdata[WIDTH-1:0]; // [RL10] [RL8]
    end
  end

  // ==========================================================================
  // Direction registers
  always @(posedge core_clk) begin
    if (sys_rst) begin
      first_port_direction <= `PPT_DIR_RESET; // [RL4] [RL2]
      second_port_direction <= `PPT_DIR_RESET; // [RL7]
      third_port_direction <= `PPT_DIR_RESET; // [RL9]
    end else if (reg_wr) begin
      case (reg_addr)
        `PPT_OFS_A_DIR: begin
          first_port_direction <= reg_wdata[WIDTH-1:0]; // [RL1]
        end
        `PPT_OFS_B_DIR: begin
          if (!ppt_is_bus(op_mode)) begin
            second_port_direction <= reg_wdata[WIDTH-1:0]; // [RL6]
          end
        end
        `PPT_OFS_C_DIR: begin
          if (!ppt_is_bus(op_mode)) begin
            third_port_direction <= reg_wdata[WIDTH-1:0]; // [RL8]
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Read mux; unmapped offsets read zero
  always @* begin
    next_rdata = `PPT_ZERO8;
    case (reg_addr)
      `PPT_OFS_A_DATA: next_rdata = ppt_read_mix(first_port_direction,
        first_port_latch, first_level); // [RL13]
      `PPT_OFS_A_DIR: next_rdata = first_port_direction;
      `PPT_OFS_B_DIR: next_rdata = ppt_is_bus(op_mode) ? `PPT_ZERO8 :
        second_port_direction; // [RL6]
      `PPT_OFS_B_DATA: next_rdata = ppt_is_bus(op_mode) ? `PPT_ZERO8 :
        ppt_read_mix(second_port_direction, second_port_latch, second_level);
      `PPT_OFS_C_DATA: next_rdata = ppt_is_bus(op_mode) ? `PPT_ZERO8 :
        ppt_read_mix(third_port_direction, third_port_latch, third_level);
      `PPT_OFS_C_DIR: next_rdata = ppt_is_bus(op_mode) ? `PPT_ZERO8 :
        third_port_direction; // [RL8]
      default: next_rdata = `PPT_ZERO8;
    endcase
  end

  // Read data one cycle after the strobe, zero otherwise
  always @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= `PPT_ZERO8;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : `PPT_ZERO8;
    end
  end

  // ==========================================================================
  // Port A pin drive: timer compare outputs override the latch
  always @* begin
    next_first_oe = first_port_direction | timer_out_en; // [RL5] [RL4]
    next_first_out = (timer_out_en & timer_out_val) |
      (~timer_out_en & first_port_latch); // [RL3]
  end

  // Registered pin outputs
  always @(posedge core_clk) begin
    if (sys_rst) begin
      first_pin_oe <= `PPT_ZERO8; // [RL2] [RL11]
      first_pin_out <= `PPT_ZERO8;
      second_pin_oe <= `PPT_ZERO8; // [RL7]
      second_pin_out <= `PPT_ZERO8;
      third_pin_oe <= `PPT_ZERO8; // [RL9]
      third_pin_out <= `PPT_ZERO8;
      timer_in <= `PPT_ZERO8;
      bus_rdata <= `PPT_ZERO8;
    end else begin
      first_pin_oe <= next_first_oe; // [RL1]
      first_pin_out <= next_first_out;
      // Capture and pulse inputs see the synchronised pin level
      timer_in <= first_level; // [RL5]
      if (bus_mode) begin
        // Address and data on separate pins, concurrently
        second_pin_oe <= `PPT_ONES8; // [RL6] [RL12]
        second_pin_out <= bus_addr_high;
        third_pin_oe <= bus_drive ? `PPT_ONES8 : `PPT_ZERO8; // [RL8] [RL12]
        third_pin_out <= bus_wdata;
      end else begin
        second_pin_oe <= second_port_direction; // [RL4]
        second_pin_out <= second_port_latch;
        third_pin_oe <= third_port_direction;
        third_pin_out <= third_port_latch;
      end
      bus_rdata <= third_level; // [RL8]
    end
  end

endmodule

// ==== sim/ppt_checker.sv ====
/* Assertions on the port block's pins and register port.
   Assumes WIDTH 8 and one bind to every ppt_ports instance. */
module ppt_checker #(
  parameter WIDTH = 8
) (
  // Clock, reset and register port
  input wire core_clk,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // Mode, timer and bus
  input wire [1:0] op_mode,
  input wire [7:0] timer_out_en,
  input wire [7:0] timer_out_val,
  input wire [7:0] timer_in,
  input wire [7:0] bus_addr_high,
  input wire [7:0] bus_wdata,
  input wire bus_drive,
  input wire [7:0] bus_rdata,
  // Pins
  input wire [WIDTH-1:0] first_pin_in,
  input wire [WIDTH-1:0] first_pin_out,
  input wire [WIDTH-1:0] first_pin_oe,
  input wire [WIDTH-1:0] second_pin_out,
  input wire [WIDTH-1:0] second_pin_oe,
  input wire [WIDTH-1:0] third_pin_in,
  input wire [WIDTH-1:0] third_pin_out,
  input wire [WIDTH-1:0] third_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ====
  // Multi-step antecedents
  sequence s_bus_mode;
    op_mode[0] [*4];
  endsequence
  sequence s_dir_wr;
    reg_wr && reg_addr == 8'h01 && timer_out_en == 8'h00 ##1 !reg_wr && timer_out_en == 8'h00;
  endsequence
  // ====
  // Checks
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_reset_hiz: assert property ($fell(sys_rst) |-> (first_pin_oe | second_pin_oe | third_pin_oe) == 8'h00)
    else $error("pin driven after reset");
  a_addr_out: assert property (s_bus_mode |-> second_pin_oe == 8'hff && second_pin_out == $past(bus_addr_high))
    else $error("address pins wrong");
  a_data_bus: assert property (s_bus_mode |-> third_pin_oe == {8{$past(bus_drive)}} && (!$past(bus_drive) || third_pin_out == $past(bus_wdata)))
    else $error("data pins wrong");
  a_map_off: assert property (op_mode[0] && reg_rd && reg_addr inside {8'h02, 8'h04, 8'h06, 8'h07} |=> reg_rdata == 8'h00)
    else $error("unmapped port readable");
  a_dir_drive: assert property (s_dir_wr |=> first_pin_oe == $past(reg_wdata, 2))
    else $error("direction not on pins");
  a_alt_owns: assert property ((timer_out_en == 8'hff) [*2] |-> first_pin_oe == 8'hff && first_pin_out == $past(timer_out_val))
    else $error("compare output not on pin");
  a_capture_in: assert property ($stable(first_pin_in) [*8] |-> timer_in == first_pin_in)
    else $error("capture input stale");
  a_bus_in: assert property ($stable(third_pin_in) [*8] |-> bus_rdata == third_pin_in)
    else $error("bus read data stale");
endmodule
bind ppt_ports ppt_checker #(.WIDTH(WIDTH)) u_chk (.*);

// ==== sim/ppt_pin_model.sv ====
/* Far side of one port: an outside driver or the memory data bus.
   Assumes the bench sets the outside level; the device wins where it drives. */
module ppt_pin_model (
  // Device side
  input wire [7:0] pin_out,
  input wire [7:0] pin_oe,
  // Outside level and resolved wire
  input wire [7:0] ext_val,
  output logic [7:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Wire level; enabled bits follow the device output pin_out
  assign pin = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule

// ==== sim/tb.sv ====
/* Self-checking bench of ppt_ports with three pin models.
   Assumes ppt_checker is bound by its own file. */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0, reg_rd = 1'b0, bus_drive = 1'b0;
  logic [1:0] op_mode = 2'h0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, timer_out_en = 8'h00;
  logic [7:0] timer_out_val = 8'h00, bus_addr_high = 8'h00, bus_wdata = 8'h00;
  logic [7:0] reg_rdata, timer_in, bus_rdata, d, dr, v;
  logic [7:0] pin_in [3], pin_out [3], pin_oe [3], ext [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] dat_ofs [3] = '{8'h00, 8'h04, 8'h06}, dir_ofs [3] = '{8'h01, 8'h02, 8'h07};
  int fails = 0, n_compared = 0, p;
  // 25 MHz clock
  always #20 core_clk = ~core_clk;
  ppt_ports DUT (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .op_mode(op_mode), .timer_out_en(timer_out_en), .timer_out_val(timer_out_val),
    .timer_in(timer_in), .bus_addr_high(bus_addr_high), .bus_wdata(bus_wdata),
    .bus_drive(bus_drive), .bus_rdata(bus_rdata), .first_pin_in(pin_in[0]),
    .first_pin_out(pin_out[0]), .first_pin_oe(pin_oe[0]), .second_pin_in(pin_in[1]),
    .second_pin_out(pin_out[1]), .second_pin_oe(pin_oe[1]), .third_pin_in(pin_in[2]),
    .third_pin_out(pin_out[2]), .third_pin_oe(pin_oe[2]));
  for (genvar i = 0; i < 3; i++) begin : g_far
    ppt_pin_model u_far (.pin_out(pin_out[i]), .pin_oe(pin_oe[i]), .ext_val(ext[i]),
      .pin(pin_in[i]));
  end
  // ====
  // Helpers
  function automatic logic [7:0] mix(input logic [7:0] dir, lat, pin);
    return (dir & lat) | (~dir & pin);
  endfunction
  task automatic chk(input logic [7:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, dat);
    @(posedge core_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, dat};
    @(posedge core_clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(posedge core_clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge core_clk) reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard
  initial begin
    #3000000;
    fails++;
    close_out;
  end
  // ====
  // Tests
  initial begin
    void'($urandom(90617));
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    #1 chk(pin_oe[0] | pin_oe[1] | pin_oe[2], 8'h00);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h00);
    rd(8'h05, 8'h00);
    $display("reset test done");
    // Random latch, direction and pin levels on every port
    for (int k = 0; k < 12; k++) begin
      p = k % 3;
      d = $urandom;
      dr = (k < 3) ? 8'hff : 8'($urandom);
      ext[p] <= $urandom;
      wr(dat_ofs[p], d);
      wr(dir_ofs[p], dr);
      repeat (6) @(posedge core_clk);
      #1 chk(pin_oe[p], dr);
      chk(pin_out[p] & dr, d & dr);
      rd(dat_ofs[p], mix(dr, d, ext[p]));
    end
    $display("random test done");
    // Latches survive a mid-run reset
    wr(8'h00, 8'ha5);
    wr(8'h04, 8'h3c);
    @(posedge core_clk) sys_rst <= 1'b1;
    @(posedge core_clk) sys_rst <= 1'b0;
    rd(8'h01, 8'h00);
    wr(8'h01, 8'hff);
    wr(8'h02, 8'hff);
    rd(8'h00, 8'ha5);
    rd(8'h04, 8'h3c);
    $display("reset keep test done");
    // Compare outputs own port A pins
    for (int j = 0; j < 2; j++) begin
      v = $urandom;
      @(posedge core_clk) {timer_out_en, timer_out_val} <= {j ? 8'hff : 8'h0f, v};
      wr(8'h00, 8'h00);
      repeat (3) @(posedge core_clk);
      #1 chk(pin_out[0], v & (j ? 8'hff : 8'h0f));
      chk(pin_oe[0], 8'hff);
      rd(8'h00, 8'h00);
      // Capture inputs trail the pin by the sync chain plus one flop
      repeat (2) @(posedge core_clk);
      #1 chk(timer_in, v & (j ? 8'hff : 8'h0f));
    end
    @(posedge core_clk) timer_out_en <= 8'h00;
    $display("timer test done");
    // Every mode code: bus takeover of ports B and C
    wr(8'h02, 8'h00);
    wr(8'h07, 8'h00);
    ext[1] <= $urandom;
    ext[2] <= $urandom;
    for (int m = 0; m < 4; m++) begin
      v = $urandom;
      @(posedge core_clk) {op_mode, bus_addr_high, bus_wdata, bus_drive} <= {m[1:0], v, ~v, v[0]};
      // Mode flop, pin flop, sync chain and bus read flop
      repeat (8) @(posedge core_clk);
      #1 chk(pin_oe[1], m[0] ? 8'hff : 8'h00);
      chk(pin_out[1] & pin_oe[1], m[0] ? v : 8'h00);
      chk(pin_oe[2], (m[0] & v[0]) ? 8'hff : 8'h00);
      chk(bus_rdata, (m[0] & v[0]) ? ~v : ext[2]);
      rd(8'h04, m[0] ? 8'h00 : ext[1]);
      wr(8'h07, 8'hff);
      rd(8'h07, m[0] ? 8'h00 : 8'hff);
      wr(8'h07, 8'h00);
    end
    $display("mode test done");
    close_out;
  end
endmodule
